/* shared/alert_pkg.sv */
// Contract
// - Only six event sources, gated by global enable, may drive the alert.
// - Status bit 7 reads 1 when any flag and its enable are both set.
// - Alert output low while pending bit is 1 and global enable is 1.
// - Buffer fault bit 6 sets on overrun or underrun, holds until host clears.
// - Late collision bit sets on collision after 64 bytes, host clearable.
// - Receive active bit 2 follows the receive logic busy state.
// - Transmit aborted bit 1 sets on abort, host clearable.
// - Oscillator ready bit 0 is 0 while startup timer counts, then 1.
// - Oscillator ready clears only at power-on reset.
// - Enable bit 6 unmasks the receive pending flag.
// - Enable bit 3 unmasks the transmit done flag.
// - Enable bit 0 unmasks the receive error flag.
// - Status bits 5 and 3 read as 0.
// - Flags set on their condition regardless of enables, link change excepted.
// - Alert stays low until every causing flag is cleared or masked.
// - Re-setting global enable with a pending flag gives a fresh falling edge.
package alert_pkg;

   // ****************************************
   // Register field positions
   // ****************************************
   localparam int EN_RXERR   = 0;
   localparam int EN_TXERR   = 1;
   localparam int EN_RSVD    = 2;
   localparam int EN_TXDONE  = 3;
   localparam int EN_LINK    = 4;
   localparam int EN_COPY    = 5;
   localparam int EN_RXPEND  = 6;
   localparam int EN_GLOBAL  = 7;

   localparam int ST_OSCRDY  = 0;
   localparam int ST_TXABORT = 1;
   localparam int ST_RXACT   = 2;
   localparam int ST_LATE_COLLISION = 4;
   localparam int ST_BUFFLT  = 6;
   localparam int ST_PEND    = 7;

   // ****************************************
   // Reset values and enable write mask
   // ****************************************
   localparam logic [7:0] ENABLE_RESET = 8'h00;
   localparam logic [7:0] FLAGS_RESET  = 8'h00;
   localparam logic [7:0] ENABLE_MASK  = 8'hFB;

   typedef struct packed {
      logic rx_error;
      logic tx_error;
      logic tx_done;
      logic link_change;
      logic copy_done;
      logic rx_pending;
      logic buffer_fault;
      logic late_collision;
      logic tx_aborted;
   } event_type;

   typedef struct packed {
      logic       wr;
      logic       clr;
      logic [7:0] data;
   } reg_access_type;

endpackage

/* verilog/interrupt_status_enable.sv */
`timescale 1ns/1ps
module interrupt_status_enable
   import alert_pkg::*;
(
   input  wire logic           clk_i,
   input  wire logic           rst_b_i,
   input  wire logic           por_b_i,
   input  wire event_type      event_i,
   input  wire logic           rx_active_i,
   input  wire logic           timer_expired_i,
   input  wire logic           zero_packets_i,
   input  wire logic           phy_status_read_i,
   input  wire reg_access_type enable_acc_i,
   input  wire reg_access_type flags_acc_i,
   input  wire reg_access_type status_acc_i,
   output logic [7:0]          irq_enable_reg_o,
   output logic [7:0]          event_flag_reg_o,
   output logic [7:0]          status_flags_reg_o,
   output logic                alert_b_o
);

   // ****************************************
   // State
   // ****************************************
   logic [7:0] enable_q;
   logic [7:0] enable_d;
   logic [7:0] flags_q;
   logic [7:0] flags_d;
   logic       buffer_fault_q;
   logic       buffer_fault_d;
   logic       late_collision_q;
   logic       late_collision_d;
   logic       tx_aborted_q;
   logic       tx_aborted_d;
   logic       osc_ready_q;
   logic       osc_ready_d;
   logic       rx_active_d;
   logic       alert_b_q;
   logic       alert_b_d;
   logic       pending;
   logic       alert_on;
   logic [7:0] source_hits;
   logic [7:0] status_clr;
   logic [7:0] status_rd;
   logic [7:0] status_rst;

   // Clearable bit: set wins over a host clear
   function automatic logic sticky(input logic cur, input logic set,
                                   input logic clr);
      sticky = set | (cur & ~clr);
   endfunction

   // Enabled flags among the six sources that may alert
   function automatic logic [7:0] masked_hits(input logic [7:0] flags,
                                              input logic [7:0] enable);
      logic [7:0] srcs;
      srcs            = 8'h00;
      srcs[EN_RXERR]  = 1'b1;
      srcs[EN_TXERR]  = 1'b1;
      srcs[EN_TXDONE] = 1'b1;
      srcs[EN_LINK]   = 1'b1;
      srcs[EN_COPY]   = 1'b1;
      srcs[EN_RXPEND] = 1'b1;
      masked_hits     = flags & enable & srcs;
   endfunction

   // ****************************************
   // Enable register
   // ****************************************
   always_comb
   begin
      enable_d = enable_q;
      if (enable_acc_i.wr)
      begin
         enable_d = enable_acc_i.data & ENABLE_MASK;
      end
      else if (enable_acc_i.clr)
      begin
         enable_d = enable_q & ~enable_acc_i.data;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         enable_q <= ENABLE_RESET;
      end
      else
      begin
         enable_q <= enable_d;
      end
   end

   // ****************************************
   // Event flags
   // ****************************************
   always_comb
   begin
      logic [7:0] setv;
      logic [7:0] clrv;
      setv = 8'h00;
      clrv = 8'h00;
      // Host bit-field clear reaches the four host clearable flags
      if (flags_acc_i.clr)
      begin
         clrv[EN_RXERR]  = flags_acc_i.data[EN_RXERR];
         clrv[EN_TXERR]  = flags_acc_i.data[EN_TXERR];
         clrv[EN_TXDONE] = flags_acc_i.data[EN_TXDONE];
         clrv[EN_COPY]   = flags_acc_i.data[EN_COPY];
      end
      // Receive pending and link change follow their own clear events
      clrv[EN_RXPEND] = zero_packets_i;
      clrv[EN_LINK]   = phy_status_read_i;
      // Unused positions never hold a flag
      clrv[EN_RSVD]   = 1'b1;
      clrv[EN_GLOBAL] = 1'b1;
      // Set on the event alone, whatever the enables
      setv[EN_RXERR]  = event_i.rx_error;
      setv[EN_TXERR]  = event_i.tx_error;
      setv[EN_TXDONE] = event_i.tx_done;
      setv[EN_COPY]   = event_i.copy_done;
      setv[EN_RXPEND] = event_i.rx_pending;
      // Link change only latched while its enable is set
      setv[EN_LINK]   = event_i.link_change & enable_q[EN_LINK];
      for (int i = 0; i < 8; i++)
      begin
         flags_d[i] = sticky(flags_q[i], setv[i], clrv[i]);
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         flags_q <= FLAGS_RESET;
      end
      else
      begin
         flags_q <= flags_d;
      end
   end

   // ****************************************
   // Status bits
   // ****************************************
   always_comb
   begin
      status_clr = 8'h00;
      if (status_acc_i.clr)
      begin
         status_clr = status_acc_i.data;
      end
      buffer_fault_d   = sticky(buffer_fault_q, event_i.buffer_fault,
                                status_clr[ST_BUFFLT]);
      late_collision_d = sticky(late_collision_q, event_i.late_collision,
                                status_clr[ST_LATE_COLLISION]);
      tx_aborted_d     = sticky(tx_aborted_q, event_i.tx_aborted,
                                status_clr[ST_TXABORT]);
      // Level from the receive logic, not latched
      rx_active_d      = rx_active_i;
      // Power-on reset pulls the bit low in the same cycle
      osc_ready_d      = por_b_i & (osc_ready_q | timer_expired_i);
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         buffer_fault_q   <= 1'b0;
         late_collision_q <= 1'b0;
         tx_aborted_q     <= 1'b0;
      end
      else
      begin
         buffer_fault_q   <= buffer_fault_d;
         late_collision_q <= late_collision_d;
         tx_aborted_q     <= tx_aborted_d;
      end
   end

   // ****************************************
   // Oscillator ready
   // ****************************************
   // Survives all resets but power-on
   always_ff @(posedge clk_i)
   begin
      if (!por_b_i)
      begin
         osc_ready_q <= 1'b0;
      end
      else
      begin
         osc_ready_q <= osc_ready_d;
      end
   end

   // ****************************************
   // Pending
   // ****************************************
   always_comb
   begin
      // Next values, so the status copy tracks the registers it mirrors
      source_hits = masked_hits(flags_d, enable_d);
      pending     = |source_hits;
      alert_on    = pending & enable_d[EN_GLOBAL];
   end

   // ****************************************
   // Alert output
   // ****************************************
   always_comb
   begin
      alert_b_d = 1'b1;
      if (alert_on)
      begin
         alert_b_d = 1'b0;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         alert_b_q <= 1'b1;
      end
      else
      begin
         alert_b_q <= alert_b_d;
      end
   end

   // ****************************************
   // Status register
   // ****************************************
   always_comb
   begin
      status_rd             = 8'h00;
      status_rd[ST_PEND]    = pending;
      status_rd[ST_BUFFLT]  = buffer_fault_d;
      status_rd[ST_LATE_COLLISION] = late_collision_d;
      status_rd[ST_RXACT]   = rx_active_d;
      status_rd[ST_TXABORT] = tx_aborted_d;
      status_rd[ST_OSCRDY]  = osc_ready_d;
      // Only the oscillator bit outlives a plain reset
      status_rst            = 8'h00;
      status_rst[ST_OSCRDY] = osc_ready_d;
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         status_flags_reg_o <= status_rst;
      end
      else
      begin
         status_flags_reg_o <= status_rd;
      end
   end

   // ****************************************
   // Register outputs
   // ****************************************
   assign alert_b_o        = alert_b_q;
   assign irq_enable_reg_o = enable_q;
   assign event_flag_reg_o = flags_q;

endmodule

/* verification/alert_monitor.sv */
`timescale 1ns/1ps
module alert_monitor
   import alert_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rst_b_i,
   input  wire logic       por_b_i,
   input  wire event_type  event_i,
   input  wire logic       rx_active_i,
   input  wire logic [7:0] irq_enable_reg_o,
   input  wire logic [7:0] event_flag_reg_o,
   input  wire logic [7:0] status_flags_reg_o,
   input  wire logic       alert_b_o
);
   wire logic [7:0] en_w = irq_enable_reg_o;
   wire logic [7:0] fl_w = event_flag_reg_o;
   wire logic [7:0] st_w = status_flags_reg_o;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   AST_PEND: assert property (st_w[7] == |(fl_w[6:0] & en_w[6:0]))
      else $error("pending bit wrong");
   AST_ALERT: assert property (alert_b_o == !(st_w[7] && en_w[7]))
      else $error("alert level wrong");
   AST_OFF: assert property (!en_w[7] |-> alert_b_o)
      else $error("alert low while disabled");
   AST_ZERO: assert property (st_w[5] == 1'b0 && st_w[3] == 1'b0)
      else $error("status spare bits set");
   AST_RESET: assert property ($rose(rst_b_i) |-> en_w == 8'h00)
      else $error("enable not cleared");
   AST_BUF: assert property (event_i.buffer_fault |=> st_w[6])
      else $error("buffer fault missed");
   AST_LATE: assert property (event_i.late_collision |=> st_w[4])
      else $error("late collision missed");
   AST_ABORT: assert property (event_i.tx_aborted |=> st_w[1])
      else $error("abort missed");
   AST_RXACT: assert property ($past(rst_b_i) |-> st_w[2] == $past(rx_active_i))
      else $error("receive active wrong");
   AST_OSC: assert property ($fell(st_w[0]) |-> !$past(por_b_i))
      else $error("oscillator ready lost");
   AST_FLAG: assert property (event_i.tx_done |=> fl_w[3])
      else $error("flag not set");
   cover property ($fell(alert_b_o));
   cover property (st_w[6] && st_w[4]);
   cover property ($rose(alert_b_o) && st_w[7]);
   cover property ($fell(st_w[0]));
endmodule
bind interrupt_status_enable alert_monitor alert_monitor_inst (.clk_i(clk_i),
   .rst_b_i(rst_b_i), .por_b_i(por_b_i), .event_i(event_i), .rx_active_i(rx_active_i),
   .irq_enable_reg_o(irq_enable_reg_o), .event_flag_reg_o(event_flag_reg_o),
   .status_flags_reg_o(status_flags_reg_o), .alert_b_o(alert_b_o));

/* verification/host_alert_model.sv */
`timescale 1ns/1ps
module host_alert_model
(
   input  wire logic alert_b_i,
   output int        falls_o = 0
);
   // Host senses falling edges only
   always @(negedge alert_b_i)
      falls_o <= falls_o + 1;
endmodule

/* verification/interrupt_status_enable_test.sv */
`timescale 1ns/1ps
module interrupt_status_enable_test
   import alert_pkg::*;
;
   logic           clk_i = 0, rst_b_i = 0, por_b_i = 0, rx_act = 0, tmr = 0;
   logic           zero_pk = 0, phy_rd = 0, alert_b;
   event_type      ev = '0;
   reg_access_type acc [3] = '{default: '0};
   logic [7:0]     en_o, fl_o, st_o;
   logic [7:0]     bits [5] = '{8'h01, 8'h02, 8'h10, 8'h20, 8'h40};
   logic [8:0]     evs [5] = '{9'h100, 9'h080, 9'h020, 9'h010, 9'h008};
   int             falls, n_errors = 0, samples_checked = 0;
   always #5 clk_i = ~clk_i;
   interrupt_status_enable interrupt_status_enable_inst (.clk_i(clk_i), .rst_b_i(rst_b_i),
      .por_b_i(por_b_i), .event_i(ev), .rx_active_i(rx_act), .timer_expired_i(tmr),
      .zero_packets_i(zero_pk), .phy_status_read_i(phy_rd), .enable_acc_i(acc[0]),
      .flags_acc_i(acc[1]), .status_acc_i(acc[2]), .irq_enable_reg_o(en_o),
      .event_flag_reg_o(fl_o), .status_flags_reg_o(st_o), .alert_b_o(alert_b));
   host_alert_model host_alert_model_inst (.alert_b_i(alert_b), .falls_o(falls));
   task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
         n_errors++;
      end
   endtask
   // ****************************************
   // One-cycle access, event or side pulse
   // ****************************************
   task drive(input int sel, input logic w, input logic [7:0] d, input logic [1:0] s,
              input logic [8:0] e);
      @(posedge clk_i);
      if (sel < 3)
         acc[sel] <= '{wr: w, clr: !w, data: d};
      {zero_pk, phy_rd} <= s;
      ev <= event_type'(e);
      @(posedge clk_i);
      acc <= '{default: '0};
      {zero_pk, phy_rd} <= 2'b00;
      ev <= '0;
      #1;
   endtask
   task test_done;
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      #100000;
      n_errors++;
      test_done;
   end
   initial
   begin
      repeat (3) @(posedge clk_i);
      rst_b_i <= 1;
      por_b_i <= 1;
      #1;
      chk("enable", 8'h00, en_o);
      drive(0, 1, 8'hFB, 0, 0);
      chk("enable", 8'hFB, en_o);
      drive(0, 1, 8'h08, 0, 0);
      drive(3, 0, 0, 0, 9'h040);
      chk("flags", 8'h08, fl_o);
      chk("status", 8'h80, st_o);
      chk("alert", 8'h01, {7'h00, alert_b});
      drive(0, 1, 8'h88, 0, 0);
      chk("falls", 8'h01, falls[7:0]);
      drive(0, 0, 8'h80, 0, 0);
      chk("alert", 8'h01, {7'h00, alert_b});
      drive(0, 1, 8'h88, 0, 0);
      chk("falls", 8'h02, falls[7:0]);
      chk("alert", 8'h00, {7'h00, alert_b});
      drive(1, 0, 8'h08, 0, 0);
      chk("flags", 8'h00, fl_o);
      chk("alert", 8'h01, {7'h00, alert_b});
      for (int k = 0; k < 5; k++)
      begin
         drive(0, 1, 8'h80 | bits[k], 0, 0);
         drive(3, 0, 0, 0, evs[k]);
         chk("falls", 8'(k + 3), falls[7:0]);
         drive(1, 0, bits[k], 0, 0);
         chk("flags", (k == 2 || k == 4) ? bits[k] : 8'h00, fl_o);
         drive(3, 0, 0, {k == 4, k == 2}, 0);
         chk("flags", 8'h00, fl_o);
      end
      @(posedge clk_i);
      rx_act <= 1;
      tmr <= 1;
      drive(3, 0, 0, 0, 9'h007);
      chk("status", 8'h57, st_o);
      drive(2, 0, 8'h52, 0, 0);
      chk("status", 8'h05, st_o);
      @(posedge clk_i);
      rx_act <= 0;
      rst_b_i <= 0;
      @(posedge clk_i);
      rst_b_i <= 1;
      #1;
      chk("status", 8'h01, st_o);
      @(posedge clk_i);
      #1;
      chk("status", 8'h01, st_o);
      chk("enable", 8'h00, en_o);
      @(posedge clk_i);
      tmr <= 0;
      rst_b_i <= 0;
      por_b_i <= 0;
      @(posedge clk_i);
      rst_b_i <= 1;
      por_b_i <= 1;
      @(posedge clk_i);
      #1;
      chk("status", 8'h00, st_o);
      @(posedge clk_i);
      tmr <= 1;
      @(posedge clk_i);
      #1;
      chk("status", 8'h01, st_o);
      test_done;
   end
endmodule
